// [core/asc_serial_cfg.sv]
// asc_serial_cfg: slot maps for channels 3 and 4 and master/slave clock configuration
// assumes a synchronous 8-bit register port: one-cycle write strobe, read data next cycle
`timescale 1ns/10ps
`default_nettype none
//
// Contract
// - slot codes 0..31 give tdm slot n or left-half slot n
// - slot codes 32..63 give tdm slot n or right-half slot n-32
// - channel 3 slot field is bits 5..0, reset 2
// - channel 4 slot field is bits 5..0, reset 3, at offset 0xe
// - config bit 7 selects slave (0) or master (1) role
// - config bit 6 at 0 enables automatic clock derivation
// - config bit 5 disables the pll under automatic configuration
// - in master mode bit 4 gates the driven bit clock and frame sync
// - in master mode bit 3 picks 48 khz or 44.1 khz family
// - bits 2..0 code the reference frequency, reset 2
// - second master config register at 0x14, reset 0x48
// - source mode bit chooses code table or frame-sync multiple
module asc_serial_cfg
   import asc_pkg::*;
(
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_b_in,
   // register port
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [7:0] reg_rdata_out,
   // channel slot placement
   output logic [5:0] ch3_tdm_slot_out,
   output logic ch3_right_half_out,
   output logic [4:0] ch3_half_slot_out,
   output logic [5:0] ch4_tdm_slot_out,
   output logic ch4_right_half_out,
   output logic [4:0] ch4_half_slot_out,
   // serial clock control
   output logic master_mode_out,
   output logic serial_clock_drive_out,
   output logic auto_clock_out,
   output logic pll_enable_out,
   output logic rate_family_44k_out,
   output logic ref_from_code_out,
   output logic [14:0] ref_khz_out,
   output logic [7:0] cfg_b_out
);
   logic [5:0] third_channel_slot;
   logic [5:0] fourth_channel_slot;
   logic [7:0] cfg_a;
   logic [7:0] cfg_b;
   logic reference_frequency_source_mode;

   // write decode
   wire logic wr_ch3 = reg_wr_in && (reg_addr_in == ASC_OFS_CH3);
   wire logic wr_ch4 = reg_wr_in && (reg_addr_in == ASC_OFS_CH4);
   wire logic wr_cfga = reg_wr_in && (reg_addr_in == ASC_OFS_CFGA);
   wire logic wr_cfgb = reg_wr_in && (reg_addr_in == ASC_OFS_CFGB);
   wire logic wr_src = reg_wr_in && (reg_addr_in == ASC_OFS_SRC);

   // named fields of the first master config register
   wire logic bus_role_select = cfg_a[ASC_BIT_ROLE];
   wire logic auto_clock_off = cfg_a[ASC_BIT_AUTO];
   wire logic auto_pll_off = cfg_a[ASC_BIT_PLLOFF];
   wire logic serial_clock_gating = cfg_a[ASC_BIT_GATE];
   wire logic rate_family_select = cfg_a[ASC_BIT_FAMILY];
   wire logic [2:0] reference_frequency_code = cfg_a[2:0];

   // read mux; reserved and unmapped bits read zero
   logic [7:0] next_rdata;
   always_comb begin
      unique case (reg_addr_in)
         ASC_OFS_CH3: next_rdata = {2'b00, third_channel_slot};
         ASC_OFS_CH4: next_rdata = {2'b00, fourth_channel_slot};
         ASC_OFS_CFGA: next_rdata = cfg_a;
         ASC_OFS_CFGB: next_rdata = cfg_b;
         ASC_OFS_SRC: next_rdata = {1'b0, reference_frequency_source_mode, 6'h00};
         default: next_rdata = 8'h00;
      endcase
   end

   // configuration registers; reserved slot bits are dropped on write
   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         third_channel_slot <= ASC_RST_CH3;
         fourth_channel_slot <= ASC_RST_CH4;
         cfg_a <= ASC_RST_CFGA;
         cfg_b <= ASC_RST_CFGB;
         reference_frequency_source_mode <= ASC_RST_SRC_MODE;
      end else begin
         if (wr_ch3)
            third_channel_slot <= reg_wdata_in[5:0];
         if (wr_ch4)
            fourth_channel_slot <= reg_wdata_in[5:0];
         if (wr_cfga)
            cfg_a <= reg_wdata_in;
         if (wr_cfgb)
            cfg_b <= reg_wdata_in;
         if (wr_src)
            reference_frequency_source_mode <= reg_wdata_in[ASC_BIT_SRC_MODE];
      end
   end

   // read data register
   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in)
         reg_rdata_out <= 8'h00;
      else if (reg_rd_in)
         reg_rdata_out <= next_rdata;
   end

   // derived clock controls
   wire logic next_drive = bus_role_select && !serial_clock_gating;
   wire logic next_pll = !auto_clock_off && !auto_pll_off;
   wire logic next_family = bus_role_select && rate_family_select;
   wire logic next_from_code = bus_role_select && !reference_frequency_source_mode;
   wire logic [14:0] next_ref = next_from_code ? ASC_REF_KHZ[reference_frequency_code] : 15'h0000;

   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         master_mode_out <= 1'b0;
         serial_clock_drive_out <= 1'b0;
         auto_clock_out <= 1'b1;
         pll_enable_out <= 1'b1;
         rate_family_44k_out <= 1'b0;
         ref_from_code_out <= 1'b0;
         ref_khz_out <= 15'h0000;
         cfg_b_out <= ASC_RST_CFGB;
      end else begin
         master_mode_out <= bus_role_select;
         serial_clock_drive_out <= next_drive;
         auto_clock_out <= !auto_clock_off;
         pll_enable_out <= next_pll;
         rate_family_44k_out <= next_family;
         ref_from_code_out <= next_from_code;
         ref_khz_out <= next_ref;
         cfg_b_out <= cfg_b;
      end
   end

   // slot decoders
   asc_slot_decode u_ch3 (
      .clk_sys_in(clk_sys_in),
      .rst_b_in(rst_b_in),
      .slot_in(third_channel_slot),
      .tdm_slot_out(ch3_tdm_slot_out),
      .right_half_out(ch3_right_half_out),
      .half_slot_out(ch3_half_slot_out)
   );
   asc_slot_decode u_ch4 (
      .clk_sys_in(clk_sys_in),
      .rst_b_in(rst_b_in),
      .slot_in(fourth_channel_slot),
      .tdm_slot_out(ch4_tdm_slot_out),
      .right_half_out(ch4_right_half_out),
      .half_slot_out(ch4_half_slot_out)
   );

   // assertions
   property p_slot_left;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (rst_b_in && third_channel_slot < 6'd32)
         |=> (!ch3_right_half_out && ch3_half_slot_out == $past(third_channel_slot[4:0]));
   endproperty
   a_slot_left: assert property (p_slot_left) else $error("left half slot wrong");
   property p_slot_right;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (rst_b_in && fourth_channel_slot >= 6'd32)
         |=> (ch4_right_half_out && ch4_tdm_slot_out == $past(fourth_channel_slot));
   endproperty
   a_slot_right: assert property (p_slot_right) else $error("right half slot wrong");
   property p_ch3_wr;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      wr_ch3 |=> third_channel_slot == $past(reg_wdata_in[5:0]);
   endproperty
   a_ch3_wr: assert property (p_ch3_wr) else $error("third_channel_slot not written");
   property p_ch4_rd;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (reg_rd_in && reg_addr_in == 8'h0e) |=> reg_rdata_out == {2'b00, $past(fourth_channel_slot)};
   endproperty
   a_ch4_rd: assert property (p_ch4_rd) else $error("ch4 readback wrong");
   property p_role;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (wr_cfga && reg_wdata_in[7]) |=> ##1 master_mode_out;
   endproperty
   a_role: assert property (p_role) else $error("master mode not taken");
   property p_auto;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      ##1 auto_clock_out == !$past(cfg_a[ASC_BIT_AUTO]);
   endproperty
   a_auto: assert property (p_auto) else $error("auto clock wrong");
   property p_pll;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (!auto_clock_off && auto_pll_off) |=> !pll_enable_out;
   endproperty
   a_pll: assert property (p_pll) else $error("pll not disabled");
   property p_gate;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      serial_clock_drive_out |-> $past(bus_role_select) && !$past(serial_clock_gating);
   endproperty
   a_gate: assert property (p_gate) else $error("clock driven while gated or slave");
   property p_family;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (bus_role_select && rate_family_select) |=> rate_family_44k_out;
   endproperty
   a_family: assert property (p_family) else $error("rate family wrong");
   property p_ref;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (bus_role_select && !reference_frequency_source_mode && reference_frequency_code == 3'd1)
         |=> ref_khz_out == 15'd12288;
   endproperty
   a_ref: assert property (p_ref) else $error("reference frequency wrong");
   property p_cfgb;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (reg_rd_in && reg_addr_in == 8'h14) |=> reg_rdata_out == $past(cfg_b);
   endproperty
   a_cfgb: assert property (p_cfgb) else $error("config b readback wrong");
   property p_src;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      reference_frequency_source_mode |=> !ref_from_code_out && ref_khz_out == 15'h0000;
   endproperty
   a_src: assert property (p_src) else $error("source mode ignored");
   property p_rsv;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (reg_rd_in && (reg_addr_in == 8'h0d || reg_addr_in == 8'h0e)) |=> reg_rdata_out[7:6] == 2'b00;
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bits not zero");
   c_master: cover property (@(posedge clk_sys_in) disable iff (!rst_b_in) serial_clock_drive_out);
   c_right: cover property (@(posedge clk_sys_in) disable iff (!rst_b_in) ch3_right_half_out);
   c_ref: cover property (@(posedge clk_sys_in) disable iff (!rst_b_in) ref_khz_out == 15'd24576);
endmodule
`default_nettype wire

// [core/asc_pkg.sv]
// asc_pkg: register map and field layout of the serial slot and master configuration block
// assumes an 8-bit register port with byte addresses as documented
package asc_pkg;
   localparam logic [7:0] ASC_OFS_CH3 = 8'h0d;
   localparam logic [7:0] ASC_OFS_CH4 = 8'h0e;
   localparam logic [7:0] ASC_OFS_CFGA = 8'h13;
   localparam logic [7:0] ASC_OFS_CFGB = 8'h14;
   localparam logic [7:0] ASC_OFS_SRC = 8'h16;
   localparam logic [5:0] ASC_RST_CH3 = 6'h02;
   localparam logic [5:0] ASC_RST_CH4 = 6'h03;
   localparam logic [7:0] ASC_RST_CFGA = 8'h02;
   localparam logic [7:0] ASC_RST_CFGB = 8'h48;
   localparam logic ASC_RST_SRC_MODE = 1'b0;
   localparam int ASC_BIT_ROLE = 7;
   localparam int ASC_BIT_AUTO = 6;
   localparam int ASC_BIT_PLLOFF = 5;
   localparam int ASC_BIT_GATE = 4;
   localparam int ASC_BIT_FAMILY = 3;
   localparam int ASC_BIT_SRC_MODE = 6;
   localparam int ASC_SLOT_HALF = 5;
   // reference frequencies in kHz, indexed by the frequency code
   localparam logic [14:0] ASC_REF_KHZ [8] = '{15'd12000, 15'd12288, 15'd13000, 15'd16000,
      15'd19200, 15'd19680, 15'd24000, 15'd24576};
endpackage

// [core/asc_slot_decode.sv]
// asc_slot_decode: turns a six-bit slot field into tdm slot, half and half-slot number
// assumes a registered field at its input; output is registered
`timescale 1ns/10ps
`default_nettype none
module asc_slot_decode
   import asc_pkg::*;
(
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_b_in,
   // field
   input wire logic [5:0] slot_in,
   // decoded slot
   output logic [5:0] tdm_slot_out,
   output logic right_half_out,
   output logic [4:0] half_slot_out
);
   // low five bits give the half slot, bit 5 chooses the half
   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         tdm_slot_out <= 6'h00;
         right_half_out <= 1'b0;
         half_slot_out <= 5'h00;
      end else begin
         tdm_slot_out <= slot_in;
         right_half_out <= slot_in[ASC_SLOT_HALF];
         half_slot_out <= slot_in[4:0];
      end
   end
endmodule
`default_nettype wire

// [testbench/asc_far_host.sv]
// asc_far_host: host side of the serial audio bus, counts bit clocks it receives
// assumes the device drive flag means bit clock and frame sync are running
`timescale 1ns/10ps
`default_nettype none
module asc_far_host (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_b_in,
   // device clock drive
   input wire logic drive_in,
   // received bit clock count
   output logic [15:0] edges_out
);
   // one bit clock per cycle while the device drives, none while gated or slave
   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) edges_out <= 16'h0000;
      else if (drive_in) edges_out <= edges_out + 16'h0001;
   end
endmodule
`default_nettype wire

// [testbench/asc_serial_cfg_bench.sv]
// asc_serial_cfg_bench: self-checking bench for the slot and master configuration block
// assumes one-cycle register strobes with read data one cycle after the read edge
`timescale 1ns/10ps
`default_nettype none
module asc_serial_cfg_bench;
   import asc_pkg::*;
   logic clk_sys_in = 1'b0;
   logic rst_b_in = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic rd_seen = 1'b0;
   logic [7:0] rdata, cfg_b, c;
   logic [5:0] t3, t4, v;
   logic r3, r4, mst, drv, aut, pll, fam, frc, s;
   logic [4:0] h3, h4;
   logic [14:0] khz;
   logic [15:0] edges, e0;
   logic [7:0] exp_q[$];
   logic [5:0] bnd [4] = '{6'h00, 6'h1f, 6'h20, 6'h3f};
   logic [14:0] khz_tab [8] = '{15'd12000, 15'd12288, 15'd13000, 15'd16000,
      15'd19200, 15'd19680, 15'd24000, 15'd24576};
   int failures = 0;
   int n_tests = 0;
   // 50 MHz system clock
   always #10 clk_sys_in = ~clk_sys_in;
   asc_serial_cfg asc_serial_cfg_i (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
      .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_rdata_out(rdata), .ch3_tdm_slot_out(t3), .ch3_right_half_out(r3),
      .ch3_half_slot_out(h3), .ch4_tdm_slot_out(t4), .ch4_right_half_out(r4),
      .ch4_half_slot_out(h4), .master_mode_out(mst), .serial_clock_drive_out(drv),
      .auto_clock_out(aut), .pll_enable_out(pll), .rate_family_44k_out(fam),
      .ref_from_code_out(frc), .ref_khz_out(khz), .cfg_b_out(cfg_b));
   asc_far_host asc_far_host_i (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
      .drive_in(drv), .edges_out(edges));
   task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         failures++;
         $display("mismatch %s expected %h seen %h", name, e, g);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys_in);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_sys_in);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_sys_in);
      addr <= a;
      rd <= 1'b1;
      exp_q.push_back(e);
      @(posedge clk_sys_in);
      rd <= 1'b0;
   endtask
   task automatic summarize();
      if (failures == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // read data watcher: oldest note against the answer one cycle after the strobe
   always @(posedge clk_sys_in) rd_seen <= rd;
   always @(negedge clk_sys_in) begin
      if (rd_seen) chk("rdata", {8'h00, exp_q.pop_front()}, {8'h00, rdata});
   end
   // main sequence
   initial begin
      void'($urandom(32'h8d733382));
      repeat (10) @(posedge clk_sys_in);
      rst_b_in <= 1'b1;
      repeat (3) @(posedge clk_sys_in);
      @(negedge clk_sys_in);
      chk("ctl_rst", 16'b001100, {mst, drv, aut, pll, fam, frc});
      chk("khz_rst", 16'h0000, khz);
      chk("slot_rst", {4'h0, 6'd2, 6'd3}, {t3, t4});
      chk("cfgb_rst", 16'h0048, cfg_b);
      rd_reg(ASC_OFS_CH3, 8'h02);
      rd_reg(ASC_OFS_CH4, 8'h03);
      rd_reg(ASC_OFS_CFGA, 8'h02);
      rd_reg(ASC_OFS_CFGB, 8'h48);
      rd_reg(ASC_OFS_SRC, 8'h00);
      wr_reg(8'h20, 8'hff);
      rd_reg(8'h20, 8'h00);
      // slot placement, boundaries first then random codes
      for (int i = 0; i < 12; i++) begin
         v = (i < 4) ? bnd[i] : 6'($urandom);
         wr_reg(ASC_OFS_CH3, {2'b00, v});
         wr_reg(ASC_OFS_CH4, {2'b00, ~v});
         repeat (3) @(posedge clk_sys_in);
         @(negedge clk_sys_in);
         chk("ch3_tdm", v, t3);
         chk("ch3_half", {v[5], v[4:0]}, {r3, h3});
         chk("ch4_tdm", {~v}, t4);
         chk("ch4_half", {~v[5], ~v[4:0]}, {r4, h4});
         rd_reg(ASC_OFS_CH3, {2'b00, v});
         rd_reg(ASC_OFS_CH4, {2'b00, ~v});
      end
      // master configuration, every frequency code twice, bit 7 set in the first eight passes, bits 6..3 random
      for (int i = 0; i < 16; i++) begin
         c = {~i[3] | 1'($urandom), 4'($urandom), i[2:0]};
         s = i[3] & (i[0] | 1'($urandom));
         wr_reg(ASC_OFS_CFGA, c);
         wr_reg(ASC_OFS_SRC, {1'b0, s, 6'h00});
         wr_reg(ASC_OFS_CFGB, ~c);
         repeat (2) @(posedge clk_sys_in);
         @(negedge clk_sys_in);
         chk("master", c[7], mst);
         chk("drive", c[7] & ~c[4], drv);
         chk("auto", !c[6], aut);
         chk("pll", !c[6] && !c[5], pll);
         chk("family", c[7] & c[3], fam);
         chk("from_code", c[7] & ~s, frc);
         chk("ref_khz", (c[7] & ~s) ? khz_tab[c[2:0]] : 15'd0, khz);
         chk("cfg_b", {~c}, cfg_b);
         e0 = edges;
         repeat (3) @(negedge clk_sys_in);
         chk("edges", 16'(e0 + 3 * (c[7] & ~c[4])), edges);
         rd_reg(ASC_OFS_CFGA, c);
         rd_reg(ASC_OFS_CFGB, ~c);
         rd_reg(ASC_OFS_SRC, {1'b0, s, 6'h00});
      end
      // bounded drain of outstanding reads
      for (int k = 0; k < 10 && exp_q.size() > 0; k++) @(posedge clk_sys_in);
      if (exp_q.size() > 0) failures++;
      summarize();
   end
endmodule
`default_nettype wire
